// ===== core/prs_pkg.sv
package prs_pkg;
    // datapath shape
    localparam int XLEN = 32;             // width of every register
    localparam int NREG = 32;             // general-purpose register count
    localparam int AW = 5;                // register number width
    // registers with a fixed meaning
    localparam logic [4:0] REG_ZERO = 5'h00;    // reads as zero
    localparam logic [4:0] REG_STR_DOFF = 5'h1A; // string dest bit offset
    localparam logic [4:0] REG_STR_SOFF = 5'h1B; // string src bit offset
    localparam logic [4:0] REG_STR_LEN = 5'h1C;  // string length
    localparam logic [4:0] REG_STR_DADR = 5'h1D; // string dest address
    localparam logic [4:0] REG_STR_SADR = 5'h1E; // string src address
    localparam logic [4:0] REG_LINK = 5'h1F;     // link pointer
    // reset values
    localparam logic [31:0] PC_RESET = 32'h0FFFFFF0; // fetch start address
    localparam logic [31:0] GPR_RESET = 32'h00000000;
    localparam int PC_LSB = 0;            // pc bit that is tied low
    // data access sizes seen by the alignment check
    typedef enum logic [1:0] {
        SZ_BYTE,
        SZ_HALF,
        SZ_WORD,
        SZ_RSVD
    } acc_size_e;
endpackage

// ===== core/prs_align_check.sv
`timescale 1ns/1ns
// flags a data access whose address is not aligned to its size
module prs_align_check (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_acc_valid,
    input wire prs_pkg::acc_size_e i_acc_size,
    input wire logic [1:0] i_acc_addr,
    output logic o_alignment_error_out
);
    import prs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // misalignment decode
    wire half_bad = i_acc_addr[0];           // halfword needs bit 0 low
    wire word_bad = |i_acc_addr;             // word needs both bits low
    wire size_bad = (i_acc_size == SZ_HALF) ? half_bad :
                    (i_acc_size == SZ_WORD) ? word_bad : 1'b0;
    wire err_nxt = i_acc_valid & size_bad;

    ////////////////////////////////////////////////////////////////////////
    // flag register: high through reset, then tracks each access
    // no bus-hold input: the flag keeps working while the bus is held
    logic err_r;
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            err_r <= 1'b1;
        end else begin
            err_r <= err_nxt;
        end
    end
    assign o_alignment_error_out = err_r;

    ////////////////////////////////////////////////////////////////////////
    // checks
    err_reset_a: assert property (@(posedge i_core_clk)
        i_sys_rst |=> o_alignment_error_out)
        else $error("alignment error low after reset");
    err_track_a: assert property (@(posedge i_core_clk)
        disable iff (i_sys_rst)
        (i_acc_valid && i_acc_size == SZ_WORD && i_acc_addr != 2'h0)
        |=> o_alignment_error_out)
        else $error("misaligned word access not flagged");
    err_clear_a: assert property (@(posedge i_core_clk)
        disable iff (i_sys_rst)
        !i_acc_valid |=> !o_alignment_error_out)
        else $error("alignment error without an access");
endmodule // prs_align_check

// ===== core/prs_program_regs.sv
`timescale 1ns/1ns
module prs_program_regs (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // two read ports for operands
    input wire logic [prs_pkg::AW-1:0] i_rd_a_sel,
    output logic [prs_pkg::XLEN-1:0] o_rd_a_data,
    input wire logic [prs_pkg::AW-1:0] i_rd_b_sel,
    output logic [prs_pkg::XLEN-1:0] o_rd_b_data,
    // result write port, taken at instruction completion
    input wire logic i_wr_en,
    input wire logic [prs_pkg::AW-1:0] i_wr_sel,
    input wire logic [prs_pkg::XLEN-1:0] i_wr_data,
    // jump-and-link return address write
    input wire logic i_jump_link_instruction,
    input wire logic [prs_pkg::XLEN-1:0] i_link_addr,
    // program counter
    input wire logic i_pc_load,
    input wire logic [prs_pkg::XLEN-1:0] i_pc_next,
    output logic [prs_pkg::XLEN-1:0] o_pc,
    // implicit string operands
    output logic [prs_pkg::XLEN-1:0] o_str_dst_off,
    output logic [prs_pkg::XLEN-1:0] o_str_src_off,
    output logic [prs_pkg::XLEN-1:0] o_str_length,
    output logic [prs_pkg::XLEN-1:0] o_str_dst_addr,
    output logic [prs_pkg::XLEN-1:0] o_str_src_addr,
    // data access checked for alignment
    input wire logic i_acc_valid,
    input wire prs_pkg::acc_size_e i_acc_size,
    input wire logic [1:0] i_acc_addr,
    output logic o_alignment_error_out
);
    import prs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // shape checks: the decode assumes one select code per register and
    // a 32-bit word, so any other package setting is refused up front
    if (XLEN != 32) begin : g_bad_width
        $error("register width must be 32");
    end
    if (NREG != 32) begin : g_bad_count
        $error("register count must be 32");
    end
    if (AW != $clog2(NREG)) begin : g_bad_sel
        $error("select width must match the register count");
    end
    if (REG_LINK != 5'(NREG - 1)) begin : g_bad_link
        $error("link register must be the last entry");
    end
    // an odd start address could never be fetched with bit 0 tied low
    if (PC_RESET[PC_LSB] != 1'b0) begin : g_bad_start
        $error("start address must be even");
    end

    ////////////////////////////////////////////////////////////////////////
    // storage: entry 0 is never a flop, it is a constant zero
    logic [XLEN-1:0] ent_r [1:NREG-1]; // flop words, entries 1 to 31
    // read view; entry 0 is a tie so each element has a single driver
    wire [XLEN-1:0] gpr_r [NREG];
    logic [XLEN-1:1] pc_r; // pc without its tied-low bit

    ////////////////////////////////////////////////////////////////////////
    // write decode per entry
    // link write takes entry 31 if both ports aim there, so a return
    // address is never overwritten by a stale result in the same cycle
    wire link_hit = i_jump_link_instruction;
    wire gen_hit = i_wr_en & (i_wr_sel != REG_ZERO);

    assign gpr_r[0] = GPR_RESET;

    genvar g;
    generate
        for (g = 1; g < NREG; g++) begin : g_entry
            // entry select for this register
            wire link_sel = link_hit & (g == NREG - 1);
            wire gen_sel = gen_hit & (i_wr_sel == AW'(g));
            wire [XLEN-1:0] wr_val = link_sel ? i_link_addr : i_wr_data;
            // one flop word per register, updated at completion edge
            always_ff @(posedge i_core_clk) begin
                if (i_sys_rst) begin
                    ent_r[g] <= GPR_RESET;
                end else if (link_sel | gen_sel) begin
                    ent_r[g] <= wr_val;
                end
            end
            assign gpr_r[g] = ent_r[g];
            // a plain result write to this entry lands next cycle
            entry_write_a: assert property (@(posedge i_core_clk)
                disable iff (i_sys_rst)
                i_wr_en && i_wr_sel == AW'(g) &&
                !(i_jump_link_instruction && g == NREG - 1)
                |=> gpr_r[g] == $past(i_wr_data))
                else $error("register write lost");
            // with no write naming it the entry keeps its word
            entry_hold_a: assert property (@(posedge i_core_clk)
                disable iff (i_sys_rst)
                !(i_wr_en && i_wr_sel == AW'(g)) &&
                !(i_jump_link_instruction && g == NREG - 1)
                |=> $stable(gpr_r[g]))
                else $error("register changed without a write");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // read selection: any register serves any operand role
    assign o_rd_a_data = gpr_r[i_rd_a_sel];
    assign o_rd_b_data = gpr_r[i_rd_b_sel];

    // implicit string operands straight off their registers
    assign o_str_dst_off = gpr_r[REG_STR_DOFF];
    assign o_str_src_off = gpr_r[REG_STR_SOFF];
    assign o_str_length = gpr_r[REG_STR_LEN];
    assign o_str_dst_addr = gpr_r[REG_STR_DADR];
    assign o_str_src_addr = gpr_r[REG_STR_SADR];

    ////////////////////////////////////////////////////////////////////////
    // program counter; bit 0 is not stored so no odd target can land
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            pc_r <= PC_RESET[XLEN-1:1];
        end else if (i_pc_load) begin
            pc_r <= i_pc_next[XLEN-1:1];
        end
    end
    assign o_pc = {pc_r, 1'b0};

    ////////////////////////////////////////////////////////////////////////
    // alignment flag
    prs_align_check u_align (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_acc_valid(i_acc_valid),
        .i_acc_size(i_acc_size),
        .i_acc_addr(i_acc_addr),
        .o_alignment_error_out(o_alignment_error_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_sys_rst);

    // plain result write into a register the link port leaves alone
    sequence s_gen_write;
        i_wr_en && i_wr_sel != REG_ZERO &&
        !(i_jump_link_instruction && i_wr_sel == REG_LINK);
    endsequence
    // the same register read back on port a next cycle
    sequence s_read_back;
        i_rd_a_sel == $past(i_wr_sel);
    endsequence

    zero_read_a: assert property (
        i_rd_a_sel == REG_ZERO |-> o_rd_a_data == GPR_RESET)
        else $error("register 0 read nonzero");
    zero_write_a: assert property (
        (i_wr_en && i_wr_sel == REG_ZERO) ##1 i_rd_b_sel == REG_ZERO
        |-> o_rd_b_data == GPR_RESET)
        else $error("write to register 0 took effect");
    write_read_a: assert property (
        s_gen_write ##1 s_read_back |-> o_rd_a_data == $past(i_wr_data))
        else $error("written value not read back");
    same_reg_a: assert property (
        i_rd_a_sel == i_rd_b_sel |-> o_rd_a_data == o_rd_b_data)
        else $error("read ports disagree on one register");
    link_write_a: assert property (
        i_jump_link_instruction
        |=> gpr_r[NREG-1] == $past(i_link_addr))
        else $error("return address not in link register");
    str_len_a: assert property (
        (i_wr_en && i_wr_sel == REG_STR_LEN) |=>
        o_str_length == $past(i_wr_data))
        else $error("string length register not updated");
    hold_reg_a: assert property (
        !(i_wr_en && i_wr_sel == REG_STR_SADR) |=> $stable(o_str_src_addr))
        else $error("register changed without a write");
    pc_even_a: assert property (
        o_pc[PC_LSB] == 1'b0)
        else $error("program counter odd");
    pc_load_a: assert property (
        i_pc_load |=> o_pc == {$past(i_pc_next[XLEN-1:1]), 1'b0})
        else $error("program counter load wrong");
    pc_reset_a: assert property (@(posedge i_core_clk)
        disable iff (1'b0)
        i_sys_rst ##1 !i_sys_rst |-> o_pc == PC_RESET)
        else $error("program counter reset value wrong");

    // link and result writes in one cycle, result aimed elsewhere
    sequence s_link_and_gen;
        i_jump_link_instruction && i_wr_en &&
        i_wr_sel != REG_ZERO && i_wr_sel != REG_LINK;
    endsequence
    // a write into one of the five string operand registers
    sequence s_str_write;
        i_wr_en && i_wr_sel >= REG_STR_DOFF && i_wr_sel <= REG_STR_SADR;
    endsequence

    both_write_a: assert property (
        s_link_and_gen |=>
        gpr_r[NREG-1] == $past(i_link_addr) &&
        gpr_r[$past(i_wr_sel)] == $past(i_wr_data))
        else $error("link and result write did not both land");
    // a stale result aimed at the link register must not win
    link_wins_a: assert property (
        i_jump_link_instruction && i_wr_en && i_wr_sel == REG_LINK
        |=> o_rd_a_data == $past(i_link_addr) || i_rd_a_sel != REG_LINK)
        else $error("result write overran the return address");
    str_dst_a: assert property (
        s_str_write ##0 i_wr_sel == REG_STR_DOFF |=>
        o_str_dst_off == $past(i_wr_data))
        else $error("string offset register not updated");
    str_src_a: assert property (
        s_str_write ##0 i_wr_sel == REG_STR_SOFF |=>
        o_str_src_off == $past(i_wr_data))
        else $error("string source offset not updated");
    pc_hold_a: assert property (
        !i_pc_load |=> $stable(o_pc))
        else $error("program counter moved without a load");
endmodule // prs_program_regs

// ===== testbench/prs_exec_model.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////
// execute-side stand-in: issues result and link writes, keeps a shadow
module prs_exec_model (
    input wire logic i_core_clk,
    output logic o_wr_en,
    output logic [4:0] o_wr_sel,
    output logic [31:0] o_wr_data,
    output logic o_jl,
    output logic [31:0] o_link_addr
);
    import prs_pkg::*;
    logic [31:0] shadow_r [32]; // expected register contents
    // idle outputs and a zeroed shadow before the first request
    initial begin
        {o_wr_en, o_jl, o_wr_sel, o_wr_data, o_link_addr} = '0;
        foreach (shadow_r[k]) shadow_r[k] = GPR_RESET;
    end
    // one write held for one edge; released lines show the inverse value
    task automatic put(input logic [4:0] sel, input logic [31:0] d,
                       input logic jl);
        @(posedge i_core_clk);
        #1;
        o_wr_en = 1'b1;
        o_jl = jl;
        // link carries a different word so a wrong winner shows up
        {o_wr_sel, o_wr_data, o_link_addr} = {sel, d, ~d};
        @(posedge i_core_clk);
        #1;
        {o_wr_en, o_jl} = 2'b00;
        {o_wr_sel, o_wr_data, o_link_addr} = ~{sel, d, ~d};
        // r0 stays zero; a link write beats the result on r31
        if (sel != REG_ZERO && !(jl && sel == REG_LINK))
            shadow_r[sel] = d;
        if (jl) shadow_r[REG_LINK] = ~d;
    endtask
endmodule // prs_exec_model

// ===== testbench/test_cpu_program_register_set.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////
module test_cpu_program_register_set;
    import prs_pkg::*;
    logic i_core_clk = 1'b0, i_sys_rst = 1'b1, pc_load = 1'b0;
    logic acc_valid = 1'b0, wr_en, jl;
    logic [4:0] sel_a = 5'h00, sel_b = 5'h00, wr_sel;
    logic [1:0] acc_addr = 2'h0;
    acc_size_e acc_size = SZ_BYTE;
    logic [31:0] pc_next = 32'h00000000, wr_data, link_addr, rd_a, rd_b, pc;
    logic [31:0] str_v [5]; // string operand views r26..r30
    logic err;
    int failures = 0, samples_checked = 0, seed = 15981;
    logic [31:0] d;
    // 100 MHz core clock
    initial forever #5 i_core_clk = ~i_core_clk;
    prs_exec_model xm (.i_core_clk(i_core_clk), .o_wr_en(wr_en),
        .o_wr_sel(wr_sel), .o_wr_data(wr_data), .o_jl(jl),
        .o_link_addr(link_addr));
    prs_program_regs DUT (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
        .i_rd_a_sel(sel_a), .o_rd_a_data(rd_a), .i_rd_b_sel(sel_b),
        .o_rd_b_data(rd_b), .i_wr_en(wr_en), .i_wr_sel(wr_sel),
        .i_wr_data(wr_data), .i_jump_link_instruction(jl),
        .i_link_addr(link_addr), .i_pc_load(pc_load), .i_pc_next(pc_next),
        .o_pc(pc), .o_str_dst_off(str_v[0]), .o_str_src_off(str_v[1]),
        .o_str_length(str_v[2]), .o_str_dst_addr(str_v[3]),
        .o_str_src_addr(str_v[4]), .i_acc_valid(acc_valid),
        .i_acc_size(acc_size), .i_acc_addr(acc_addr),
        .o_alignment_error_out(err));
    // verdict and end of run, shared with the watchdog
    task automatic stop_test();
        if (failures == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, exp, input string m);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: %s %h vs %h", $time, m, seen, exp);
        end
    endtask
    // half needs an even address, word needs both low bits clear
    function automatic logic exp_err(acc_size_e s, logic [1:0] a);
        return (s == SZ_HALF && a[0]) || (s == SZ_WORD && a != 2'h0);
    endfunction
    // every register through both ports, string views against r26..r30
    task automatic sweep();
        for (int r = 0; r < NREG; r++) begin
            @(posedge i_core_clk);
            #1 sel_a = 5'(r);
            sel_b = 5'(NREG - 1 - r);
            #4;
            check(rd_a, xm.shadow_r[r], "port a");
            check(rd_b, xm.shadow_r[NREG-1-r], "port b");
        end
        for (int k = 0; k < 5; k++)
            check(str_v[k], xm.shadow_r[26+k], "string view");
    endtask
    // watchdog at 10000 cycles; the whole run needs well under that
    initial begin
        #100000;
        failures++;
        stop_test();
    end
    initial begin
        repeat (20) @(posedge i_core_clk);
        #1 check(pc, PC_RESET, "pc reset");
        check(32'(err), 32'h1, "error in reset");
        i_sys_rst = 1'b0;
        sweep();
        // random writes with r0, r26..r31 hit on purpose, link writes too
        for (int n = 0; n < 48; n++) begin
            d = $random(seed);
            xm.put(n % 8 == 0 ? 5'h00 : 5'(n % 8 == 1 ? 26 + n / 8 % 6 :
                   $random(seed)), d, n % 5 == 4);
        end
        // corners: link and result on r31, link beside a string write
        d = $random(seed);
        xm.put(REG_LINK, d, 1'b1);
        d = $random(seed);
        xm.put(REG_STR_LEN, d, 1'b1);
        sweep();
        // pc loads with odd and even targets, bit 0 must read low
        for (int n = 0; n < 12; n++) begin
            @(posedge i_core_clk);
            #1 pc_next = $random(seed);
            pc_load = 1'b1;
            @(posedge i_core_clk);
            #1 pc_load = 1'b0;
            check(pc, {pc_next[31:1], 1'b0}, "pc load");
        end
        // every size and low address pair, flagged one cycle later
        for (int s = 0; s < 4; s++) for (int a = 0; a < 4; a++) begin
            @(posedge i_core_clk);
            #1 acc_valid = 1'b1;
            acc_size = acc_size_e'(s);
            acc_addr = 2'(a);
            @(posedge i_core_clk);
            #1 acc_valid = 1'b0;
            check(32'(err), 32'(exp_err(acc_size, acc_addr)), "align");
            @(posedge i_core_clk);
            #1 check(32'(err), 32'h0, "idle align");
        end
        // mid-run reset: pc, flag and registers return to reset state
        @(posedge i_core_clk);
        #1 i_sys_rst = 1'b1;
        repeat (2) @(posedge i_core_clk);
        #1 check(pc, PC_RESET, "pc second reset");
        check(32'(err), 32'h1, "error in second reset");
        i_sys_rst = 1'b0;
        for (int k = 0; k < NREG; k++) xm.shadow_r[k] = GPR_RESET;
        sweep();
        stop_test();
    end
endmodule // test_cpu_program_register_set
